// ===== design/pgc_bank.sv
/*
 * Power-good and clock-source configuration bank with its output logic.
 * Assumes monitor inputs and the external clock presence come from analog or
 * pin sources and are resynchronised here; irq_req_i, long_step_i and the
 * state inputs come from logic on core_clk_i. Register port is one-cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module pgc_bank
    import pgc_pkg::*;
#(
    parameter logic [20:0] DB_LONG_CYCLES = pgc_pkg::DB_LONG_CYC
) (
    // clock and reset
    input  wire logic                           core_clk_i,
    input  wire logic                           rst_i,
    // register port from the serial host
    input  wire logic [pgc_pkg::ADDR_W-1:0]     reg_addr_i,
    input  wire logic [pgc_pkg::DATA_W-1:0]     reg_wdata_i,
    input  wire logic                           reg_wr_i,
    input  wire logic                           reg_rd_i,
    output logic [pgc_pkg::DATA_W-1:0]          reg_rdata_o,
    // regulator monitors (asynchronous)
    input  wire logic [pgc_pkg::NUM_REG-1:0]    uv_ok_i,
    input  wire logic [pgc_pkg::NUM_REG-1:0]    ov_ok_i,
    input  wire logic [pgc_pkg::NUM_REG-1:0]    ilim_ok_i,
    input  wire logic [7:0]                     good_source_i,
    // system state and interrupt
    input  wire logic                           irq_req_i,
    input  wire logic                           long_step_i,
    input  wire logic                           state_standby_i,
    input  wire logic                           state_active_i,
    input  wire logic                           ext_clock_in_present_i,
    // outputs
    output logic                                power_good_out_o,
    output logic                                power_good_oe_o,
    output logic                                irq_out_n_o,
    output logic [pgc_pkg::STEP_W-1:0]          delay_step_cycles_o,
    output logic                                pll_enable_o,
    output logic                                use_ext_clock_o,
    output logic                                ext_clock_event_o,
    output logic [pgc_pkg::MHZ_W-1:0]           ext_clock_mhz_o
);
    logic [7:0]          ctrl;
    logic [7:0]          next_ctrl;
    logic [7:0]          fault;
    logic [7:0]          next_fault;
    logic [7:0]          clk_sel;
    logic [7:0]          next_clk_sel;
    logic [7:0]          rdata;
    logic [7:0]          next_rdata;
    logic [12:0]         sync1;
    logic [12:0]         sync2;
    logic                ext_prev;
    logic                next_ext_prev;
    logic                ext_evt;
    logic                next_ext_evt;
    logic [3:0]          reg_ok;
    logic [3:0]          reg_ok_eff;
    logic [3:0]          set_mask;
    logic [3:0]          clr_mask;
    logic                live_good;
    logic                good_active;
    logic                drive_level;
    logic                ext_present;
    pgc_pll_mode_t       pll_mode;

    // decode of a register hit
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    // two-flop resync of analog and pin inputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {ext_clock_in_present_i, ilim_ok_i, ov_ok_i, uv_ok_i};
            sync2 <= sync1;
        end
    end
    assign ext_present = sync2[12];

    // per regulator validity
    for (genvar i = 0; i < NUM_REG; i++) begin : g_reg
        assign reg_ok[i] = sync2[i] & (~ctrl[BIT_WINDOW] | sync2[NUM_REG + i]);
        always_comb begin
            case (pgc_src_t'(good_source_i[2*i +: 2]))
                PGC_SRC_VOLT:  reg_ok_eff[i] = reg_ok[i];
                PGC_SRC_VILIM: reg_ok_eff[i] = reg_ok[i] & sync2[2*NUM_REG + i];
                default:       reg_ok_eff[i] = 1'b1;
            endcase
        end
        assign clr_mask[i] = reg_rd_i & hit(reg_addr_i, ADDR_PG_FAULT) & reg_ok_eff[i];
    end

    pgc_debounce u_debounce (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (&reg_ok_eff),
        .hold_i     (ctrl[BIT_DB_SEL] ? DB_LONG_CYCLES : DB_SHORT_CYC),
        .valid_o    (live_good)
    );

    // flag the regulator that drops power-good
    assign set_mask = {NUM_REG{live_good}} & ~reg_ok_eff;

    // register writes, fault flags and read data
    always_comb begin
        next_ctrl    = ctrl;
        next_clk_sel = clk_sel;
        next_fault   = fault;
        next_rdata   = rdata;
        if (reg_wr_i) begin
            if (hit(reg_addr_i, ADDR_PG_CTRL)) begin
                next_ctrl = reg_wdata_i;
            end else if (hit(reg_addr_i, ADDR_PG_FAULT)) begin
                next_fault[7:4] = reg_wdata_i[7:4];
            end else if (hit(reg_addr_i, ADDR_CLK_SEL)) begin
                next_clk_sel = reg_wdata_i;
            end
        end
        next_fault[3:0] = (fault[3:0] & ~clr_mask) | set_mask;
        if (reg_rd_i) begin
            if (hit(reg_addr_i, ADDR_PG_CTRL)) begin
                next_rdata = ctrl;
            end else if (hit(reg_addr_i, ADDR_PG_FAULT)) begin
                next_rdata = fault;
            end else if (hit(reg_addr_i, ADDR_CLK_SEL)) begin
                next_rdata = clk_sel;
            end else begin
                next_rdata = RESET_VALUE;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl    <= RESET_VALUE;
            fault   <= RESET_VALUE;
            clk_sel <= RESET_VALUE;
            rdata   <= RESET_VALUE;
        end else begin
            ctrl    <= next_ctrl;
            fault   <= next_fault;
            clk_sel <= next_clk_sel;
            rdata   <= next_rdata;
        end
    end
    assign reg_rdata_o = rdata;

    // latched mode holds off on flags
    assign good_active = live_good & ~(ctrl[BIT_LATCHED] & (|fault[3:0]));
    assign drive_level = good_active ^ ctrl[BIT_POLARITY];
    assign power_good_out_o = ctrl[BIT_OPEN_DRAIN] ? 1'b0 : drive_level;
    assign power_good_oe_o  = ctrl[BIT_OPEN_DRAIN] ? ~drive_level : 1'b1;

    assign irq_out_n_o = ~(irq_req_i | (ctrl[BIT_MERGE] & ~reg_ok_eff[0]));

    always_comb begin
        case ({ctrl[BIT_SHORT_STEP], long_step_i})
            2'h0:    delay_step_cycles_o = STEP_NORM_CYC;
            2'h1:    delay_step_cycles_o = STEP_DBL_CYC;
            2'h2:    delay_step_cycles_o = STEP_HALF_CYC;
            default: delay_step_cycles_o = STEP_HDBL_CYC;
        endcase
    end

    assign pll_mode = pgc_pll_mode_t'(clk_sel[PLL_MODE_HI:PLL_MODE_LO]);
    always_comb begin
        case (pll_mode)
            PGC_PLL_STBY_ACT: pll_enable_o = state_standby_i | state_active_i;
            PGC_PLL_ACT:      pll_enable_o = state_active_i;
            default:          pll_enable_o = 1'b0;
        endcase
    end
    assign use_ext_clock_o = pll_enable_o & ext_present;

    always_comb begin
        next_ext_prev = ext_present;
        next_ext_evt  = (pll_mode == PGC_PLL_STBY_ACT || pll_mode == PGC_PLL_ACT)
                        && (ext_present != ext_prev);
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ext_prev <= 1'b0;
            ext_evt  <= 1'b0;
        end else begin
            ext_prev <= next_ext_prev;
            ext_evt  <= next_ext_evt;
        end
    end
    assign ext_clock_event_o = ext_evt;

    assign ext_clock_mhz_o = {1'b0, clk_sel[FREQ_HI:FREQ_LO]} + 6'h01;

    a_merge_irq_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ctrl[BIT_MERGE] && !reg_ok_eff[0]) |-> !irq_out_n_o)
        else $error("merged regulator 0 fault did not pull interrupt low");
    a_merge_off_isolates: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !ctrl[BIT_MERGE] |-> (irq_out_n_o == !irq_req_i))
        else $error("power-good leaked into interrupt");
    a_latched_holds_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ctrl[BIT_LATCHED] && fault[3:0] != 4'h0) |-> (drive_level == ctrl[BIT_POLARITY]))
        else $error("latched mode showed valid with a fault flag set");
    a_push_pull_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !ctrl[BIT_OPEN_DRAIN] |-> power_good_oe_o
            && (power_good_out_o == ((live_good && !(ctrl[BIT_LATCHED] && |fault[3:0]))
                                      ^ ctrl[BIT_POLARITY])))
        else $error("push-pull level wrong");
    a_open_drain_only_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ctrl[BIT_OPEN_DRAIN] |-> !power_good_out_o)
        else $error("open-drain output drove high");
    a_fault_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (fault[0] && !(reg_rd_i && hit(reg_addr_i, ADDR_PG_FAULT) && reg_ok_eff[0]))
            |=> fault[0])
        else $error("fault flag 0 cleared without a valid read");
    a_fault_set_on_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (live_good && !reg_ok_eff[1]) |=> fault[1])
        else $error("fault flag 1 not set on drop");
    a_pll_mode_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (pll_mode == PGC_PLL_OFF) |-> (!pll_enable_o && !use_ext_clock_o ##1 !ext_clock_event_o))
        else $error("pll active in internal oscillator mode");
    a_step_short_long: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ctrl[BIT_SHORT_STEP] && long_step_i) |-> (delay_step_cycles_o == 17'h0FA00))
        else $error("short long delay step is not 64000 cycles");
endmodule : pgc_bank
`default_nettype wire

// ===== design/pgc_debounce.sv
/*
 * Rise-only debounce of the combined valid level.
 * Assumes raw_i is already synchronous to core_clk_i; hold_i is at least 1.
 */
`timescale 1ns/100ps
`default_nettype none
module pgc_debounce
    import pgc_pkg::*;
(
    // clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    // level in and out
    input  wire logic                    raw_i,
    input  wire logic [pgc_pkg::DB_W-1:0] hold_i,
    output logic                         valid_o
);
    typedef enum logic {
        PGC_DB_INVALID = 1'b0,
        PGC_DB_VALID   = 1'b1
    } pgc_db_state_t;

    pgc_db_state_t       state;
    pgc_db_state_t       next_state;
    logic [DB_W-1:0]     cnt;
    logic [DB_W-1:0]     next_cnt;

    always_comb begin
        next_state = state;
        next_cnt   = '0;
        case (state)
            PGC_DB_INVALID: begin
                if (raw_i) begin
                    next_cnt = cnt + 21'h000001;
                    if (next_cnt >= hold_i) begin
                        next_state = PGC_DB_VALID;
                        next_cnt   = '0;
                    end
                end
            end
            default: begin
                if (!raw_i) begin
                    next_state = PGC_DB_INVALID;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= PGC_DB_INVALID;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign valid_o = (state == PGC_DB_VALID);

    a_db_fall_fast: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (valid_o && !raw_i) |=> !valid_o)
        else $error("debounce did not drop at once");
    a_db_rise_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!valid_o ##1 valid_o) |-> ($past(cnt) + 21'h000001 >= $past(hold_i)) && $past(raw_i))
        else $error("debounce rose before its hold time");
endmodule : pgc_debounce
`default_nettype wire

// ===== design/pgc_pkg.sv
/*
 * Constants for the power-good and clock-source configuration bank: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock and an 8-bit register port behind the serial host.
 */
package pgc_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned NUM_REG       = 4;
    localparam logic [7:0]  ADDR_PG_CTRL  = 8'h29;
    localparam logic [7:0]  ADDR_PG_FAULT = 8'h2A;
    localparam logic [7:0]  ADDR_CLK_SEL  = 8'h2B;
    localparam logic [7:0]  RESET_VALUE   = 8'h00;

    // power_good_control fields
    localparam int unsigned BIT_SHORT_STEP = 7;
    localparam int unsigned BIT_MERGE      = 6;
    localparam int unsigned BIT_DB_SEL     = 5;
    localparam int unsigned BIT_LATCHED    = 4;
    localparam int unsigned BIT_WINDOW     = 2;
    localparam int unsigned BIT_OPEN_DRAIN = 1;
    localparam int unsigned BIT_POLARITY   = 0;
    // clock_source_select fields
    localparam int unsigned PLL_MODE_HI  = 7;
    localparam int unsigned PLL_MODE_LO  = 6;
    localparam int unsigned FREQ_HI      = 4;
    localparam int unsigned FREQ_LO      = 0;
    localparam int unsigned FREQ_W       = 5;
    localparam int unsigned MHZ_W        = 6;

    typedef enum logic [1:0] {
        PGC_PLL_OFF      = 2'h0,
        PGC_PLL_STBY_ACT = 2'h1,
        PGC_PLL_ACT      = 2'h2,
        PGC_PLL_RSVD     = 2'h3
    } pgc_pll_mode_t;

    typedef enum logic [1:0] {
        PGC_SRC_MASKED = 2'h0,
        PGC_SRC_VOLT   = 2'h1,
        PGC_SRC_RSVD   = 2'h2,
        PGC_SRC_VILIM  = 2'h3
    } pgc_src_t;

    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STEP_W        = 17;
    localparam int unsigned STEP_NORM_NS  = 500000;
    localparam int unsigned STEP_DBL_NS   = 1000000;
    localparam int unsigned STEP_HALF_NS  = 320000;
    localparam int unsigned STEP_HDBL_NS  = 640000;
    localparam logic [16:0] STEP_NORM_CYC =
        17'((STEP_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [16:0] STEP_DBL_CYC  = 17'((STEP_DBL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [16:0] STEP_HALF_CYC =
        17'((STEP_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [16:0] STEP_HDBL_CYC =
        17'((STEP_HDBL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned DB_W          = 21;
    localparam int unsigned DB_SHORT_NS   = 4000;
    localparam int unsigned DB_LONG_NS    = 11000000;
    localparam logic [20:0] DB_SHORT_CYC  = 21'((DB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [20:0] DB_LONG_CYC   = 21'((DB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : pgc_pkg

// ===== tb/pgc_good_receiver.sv
/*
 * System-side receiver of the power-good pin.
 * Assumes a board pull-up on the pin; the bank's enable is high while driving.
 */
`timescale 1ns/100ps
`default_nettype none
module pgc_good_receiver (
    // pin as driven by the bank
    input  wire logic drive_i,
    input  wire logic enable_i,
    // level seen on the board
    output logic      level_o
);
    assign level_o = enable_i ? drive_i : 1'b1;
endmodule : pgc_good_receiver
`default_nettype wire

// ===== tb/power_good_and_clock_config_test.sv
/*
 * Self-checking bench for the power-good and clock-source bank.
 * Assumes the one-cycle register port and a pulled-up power-good pin.
 */
`timescale 1ns/100ps
`default_nettype none
module power_good_and_clock_config_test;
    import pgc_pkg::*;
    localparam logic [20:0] DB_LONG = 21'h32;
    logic        core_clk_i  = 1'b0;
    logic        rst_i       = 1'b1;
    logic [7:0]  addr        = 8'h00;
    logic [7:0]  wdata       = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [3:0]  uv          = 4'hF;
    logic [3:0]  ov          = 4'hF;
    logic [3:0]  ilim        = 4'hF;
    logic [7:0]  src         = 8'h55;
    logic        irq_req     = 1'b0;
    logic        long_step   = 1'b0;
    logic        stby        = 1'b0;
    logic        act         = 1'b0;
    logic        ext_present = 1'b0;
    logic [7:0]  ctrl        = 8'h00;
    logic [7:0]  rdata, v, d;
    logic [4:0]  f;
    logic [16:0] step;
    logic [5:0]  mhz;
    logic        pg_out, pg_oe, irq_n, pll_en, use_ext, ev, pad;
    int          n_mismatch  = 0;
    int          num_checks  = 0;
    int          cycles      = 0;
    int          n;

    pgc_bank #(.DB_LONG_CYCLES(DB_LONG)) i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .uv_ok_i(uv), .ov_ok_i(ov), .ilim_ok_i(ilim), .good_source_i(src),
        .irq_req_i(irq_req), .long_step_i(long_step), .state_standby_i(stby),
        .state_active_i(act), .ext_clock_in_present_i(ext_present),
        .power_good_out_o(pg_out), .power_good_oe_o(pg_oe), .irq_out_n_o(irq_n),
        .delay_step_cycles_o(step), .pll_enable_o(pll_en), .use_ext_clock_o(use_ext),
        .ext_clock_event_o(ev), .ext_clock_mhz_o(mhz));
    pgc_good_receiver i_rcv (.drive_i(pg_out), .enable_i(pg_oe), .level_o(pad));

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic chk_reg(input string what, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk_reg
    task automatic chk_lvl(input string what, input logic [16:0] e, input logic [16:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk_lvl
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] dt);
        addr = a;
        wdata = dt;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] dt);
        addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(1);
        dt = rdata;
    endtask : rd_reg
    task automatic set_ctrl(input logic [7:0] c);
        ctrl = c;
        wr_reg(ADDR_PG_CTRL, c);
    endtask : set_ctrl
    task automatic check_pad(input logic good);
        chk_lvl("good pin level", {16'h0000, good ^ ctrl[0]}, 17'(pad));
        chk_lvl("good pin enable", {16'h0000, ~ctrl[1] | ~(good ^ ctrl[0])}, 17'(pg_oe));
    endtask : check_pad

    function automatic logic [16:0] exp_step(input logic s, input logic l);
        return s ? (l ? 17'h0FA00 : 17'h07D00) : (l ? 17'h186A0 : 17'h0C350);
    endfunction : exp_step
    function automatic logic exp_pll(input logic [1:0] m, input logic sb, input logic a);
        return (m == 2'h1) ? (sb | a) : (m == 2'h2) ? a : 1'b0;
    endfunction : exp_pll
    function automatic logic exp_valid(input logic [7:0] s, input logic [3:0] u,
                                       input logic [3:0] o, input logic [3:0] l,
                                       input logic win);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (s[2*i+:2] != 2'h0) begin
                ok &= u[i] & (o[i] | ~win) & (l[i] | ~s[2*i+1]);
            end
        end
        return ok;
    endfunction : exp_valid

    initial begin
        void'($urandom(89));
        tick(6);
        rst_i = 1'b0;
        for (int a = 'h29; a <= 'h2C; a++) begin
            rd_reg(8'(a), v);
            chk_reg("reset value", 8'h00, v);
        end
        chk_lvl("reset mhz", 17'h00001, 17'(mhz));
        chk_lvl("reset step", 17'h0C350, step);
        for (int k = 0; k < 5; k++) begin
            d = 8'($urandom());
            f = (k == 0) ? 5'h00 : (k == 1) ? 5'h17 : 5'($urandom_range(23));
            wr_reg(ADDR_PG_CTRL, d);
            rd_reg(ADDR_PG_CTRL, v);
            chk_reg("control readback", d, v);
            wr_reg(ADDR_PG_FAULT, d);
            rd_reg(ADDR_PG_FAULT, v);
            chk_reg("fault storage", {d[7:4], 4'h0}, v);
            wr_reg(ADDR_CLK_SEL, {1'b0, d[6:5], f});
            rd_reg(ADDR_CLK_SEL, v);
            chk_reg("clock readback", {1'b0, d[6:5], f}, v);
            chk_lvl("ext clock mhz", 17'(f) + 17'h00001, 17'(mhz));
            wr_reg(8'h30, d);
            rd_reg(8'h30, v);
            chk_reg("unmapped read", 8'h00, v);
        end
        wr_reg(ADDR_PG_FAULT, 8'h00);
        for (int k = 0; k < 4; k++) begin
            long_step = k[0];
            wr_reg(ADDR_PG_CTRL, {k[1], 7'h00});
            chk_lvl("delay step", exp_step(k[1], k[0]), step);
        end
        $display("test registers done");
        ext_present = 1'b1;
        for (int k = 0; k < 12; k++) begin
            {stby, act} = k[1:0];
            wr_reg(ADDR_CLK_SEL, {k[3:2], 6'h00});
            tick(3);
            chk_lvl("pll on", 17'(exp_pll(k[3:2], k[1], k[0])), 17'(pll_en));
            if (k < 4 || exp_pll(k[3:2], k[1], k[0])) begin
                chk_lvl("ext clock use", 17'(k >= 4), 17'(use_ext));
            end
        end
        for (int k = 0; k < 3; k++) begin
            wr_reg(ADDR_CLK_SEL, {2'(k), 6'h00});
            ext_present = ~ext_present;
            n = 0;
            repeat (8) begin
                tick(1);
                n += int'(ev);
            end
            chk_lvl("clock events", 17'(k != 0), 17'(n));
        end
        $display("test clock source done");
        set_ctrl(8'h00);
        tick(420);
        check_pad(1'b1);
        uv[2] = 1'b0;
        tick(5);
        check_pad(1'b0);
        rd_reg(ADDR_PG_FAULT, v);
        chk_reg("fault set", 8'h04, v);
        rd_reg(ADDR_PG_FAULT, v);
        chk_reg("fault kept", 8'h04, v);
        uv[2] = 1'b1;
        tick(300);
        check_pad(1'b0);
        tick(120);
        check_pad(1'b1);
        rd_reg(ADDR_PG_FAULT, v);
        chk_reg("fault before clear", 8'h04, v);
        rd_reg(ADDR_PG_FAULT, v);
        chk_reg("fault cleared", 8'h00, v);
        set_ctrl(8'h20);
        uv[3] = 1'b0;
        tick(5);
        uv[3] = 1'b1;
        tick(40);
        check_pad(1'b0);
        tick(20);
        check_pad(1'b1);
        for (int k = 0; k < 8; k++) begin
            set_ctrl({6'h00, k[1:0]});
            uv[1] = k[2];
            tick(k[2] ? 420 : 5);
            check_pad(k[2]);
        end
        $display("test pin behaviour done");
        repeat (12) begin
            uv = 4'($urandom()) | 4'($urandom());
            ov = 4'($urandom()) | 4'($urandom());
            ilim = 4'($urandom()) | 4'($urandom());
            d = 8'($urandom());
            src = d & ~(d & 8'hAA & ~(d << 1));
            irq_req = 1'($urandom());
            set_ctrl({5'h00, 1'($urandom()), 2'h0});
            tick(420);
            check_pad(exp_valid(src, uv, ov, ilim, ctrl[2]));
            chk_lvl("irq line", {16'h0000, ~irq_req}, 17'(irq_n));
        end
        {uv, ov, ilim, src, irq_req} = {12'hFFF, 8'h55, 1'b0};
        set_ctrl(8'h10);
        tick(420);
        rd_reg(ADDR_PG_FAULT, v);
        rd_reg(ADDR_PG_FAULT, v);
        chk_reg("flags clear", 8'h00, v);
        tick(5);
        check_pad(1'b1);
        uv[0] = 1'b0;
        tick(5);
        uv[0] = 1'b1;
        tick(420);
        check_pad(1'b0);
        rd_reg(ADDR_PG_FAULT, v);
        chk_reg("latched flag", 8'h01, v);
        tick(5);
        check_pad(1'b1);
        for (int k = 0; k < 8; k++) begin
            irq_req = k[0];
            uv[0] = k[1];
            set_ctrl({1'b0, k[2], 6'h00});
            tick(k[1] ? 420 : 5);
            chk_lvl("irq line", {16'h0000, ~(k[0] | (k[2] & ~k[1]))}, 17'(irq_n));
        end
        $display("test good logic done");
        conclude();
    end
endmodule : power_good_and_clock_config_test
`default_nettype wire
